// ### ctc_ctrl.sv
// controller driving the cache tag comparator pins from AXI4-Lite registers
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "ctc_defs.svh"
module ctc_ctrl
   import ctc_pkg::*;
#(
   parameter int PULSE_CYC = `CTC_PULSE_CYC,
   parameter int SETTLE_CYC = `CTC_SETTLE_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // device pins
   output ctc_pkg::ctc_pins_out_t pins_out,
   input wire ctc_pkg::ctc_pins_in_t pins_in
);
   import ctc_pkg::*;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SETUP = 5'h02,
      ST_STROBE = 5'h04,
      ST_HOLD = 5'h08,
      ST_SAMPLE = 5'h10
   } ctc_state_t;

   typedef struct packed {
      ctc_state_t state;
      logic [7:0] cnt;
      ctc_cmd_t cmd;
      logic [31:0] arg;
      logic done;
      logic [31:0] result;
      logic aw_got;
      logic w_got;
      logic [4:0] awaddr;
      logic [31:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      ctc_pins_out_t pins;
   } ctc_st_t;

   ctc_st_t st;
   ctc_st_t next_st;
   ctc_pins_in_t pin_sync;

   // counts are loaded into an eight-bit down counter
   if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
      $error("PULSE_CYC out of range");
   end
   if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
      $error("SETTLE_CYC out of range");
   end

   ctc_sync #(
      .WIDTH($bits(ctc_pins_in_t))
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(pins_in),
      .q(pin_sync)
   );

   // idle pin levels: selected, compare mode, all strobes inactive
   function automatic ctc_pins_out_t idle_pins(input logic [31:0] a);
      ctc_pins_out_t p;
      p = '0;
      p.addr = a[`CTC_ADDR_LSB +: `CTC_ADDR_W];
      p.write_n = 1'b1;
      p.read_n = 1'b1;
      p.select_n = 1'b0;
      p.auto_mode = a[`CTC_AUTO_BIT];
      p.bank_choose = a[`CTC_BANK_CHOOSE_BIT];
      p.reset_n = 1'b1;
      p.word_reset_n = 1'b1;
      p.replace_update_strobe = 1'b1;
      p.tag_out = a[`CTC_TAG_LSB +: `CTC_TAG_W];
      p.tag_oe = 1'b1;
      return p;
   endfunction

   function automatic logic [7:0] cyc8(input int n);
      return n[7:0];
   endfunction

   logic busy;
   logic wr_fire;
   logic rd_fire;
   logic start;

   always_comb begin
      next_st = st;
      busy = (st.state != ST_IDLE);
      s_axi_awready = !st.aw_got && !st.bvalid;
      s_axi_wready = !st.w_got && !st.bvalid;
      s_axi_arready = !st.rvalid;
      start = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
      end
      wr_fire = next_st.aw_got && next_st.w_got && !st.bvalid;
      if (wr_fire) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = `CTC_RESP_OKAY;
         unique case (next_st.awaddr)
            `CTC_REG_CTRL: begin
               if (next_st.wdata[`CTC_CTRL_GO] && !busy) begin
                  next_st.cmd = ctc_cmd_t'(next_st.wdata[`CTC_CMD_LSB +: 3]);
                  start = 1'b1;
               end
            end
            `CTC_REG_ARG: begin
               if (!busy) begin
                  next_st.arg = next_st.wdata;
               end
            end
            `CTC_REG_STATUS: begin
               if (next_st.wdata[`CTC_STAT_DONE]) begin
                  next_st.done = 1'b0;
               end
            end
            default: next_st.bresp = `CTC_RESP_SLVERR;
         endcase
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      rd_fire = s_axi_arvalid && !st.rvalid;
      if (rd_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = `CTC_RESP_OKAY;
         unique case (s_axi_araddr)
            `CTC_REG_CTRL: next_st.rdata = {28'h0000000, st.cmd, 1'b0};
            `CTC_REG_ARG: next_st.rdata = st.arg;
            `CTC_REG_STATUS: next_st.rdata = {30'h00000000, st.done, busy};
            `CTC_REG_RESULT: next_st.rdata = st.result;
            `CTC_REG_TIMING: next_st.rdata = {cyc8(SETTLE_CYC), cyc8(PULSE_CYC), 16'h0000};
            default: begin
               next_st.rdata = 32'h00000000;
               next_st.rresp = `CTC_RESP_SLVERR;
            end
         endcase
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      unique case (st.state)
         ST_IDLE: begin
            next_st.pins = idle_pins(st.arg);
            // stays deselected from reset until the first command
            next_st.pins.select_n = st.pins.select_n;
            if (start) begin
               next_st.pins = idle_pins(next_st.arg);
               // tags driven only for write, compare and update; floated otherwise
               next_st.pins.tag_oe = (next_st.cmd == CTC_CMD_WRITE) || (next_st.cmd == CTC_CMD_COMPARE) ||
                  (next_st.cmd == CTC_CMD_UPDATE);
               if (next_st.cmd == CTC_CMD_WORD_RESET) begin
                  next_st.pins.auto_mode = 1'b0;
               end
               // select low and address stable before any strobe
               next_st.pins.select_n = 1'b0;
               next_st.cnt = cyc8(SETTLE_CYC);
               next_st.state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (st.cnt > 8'h01) begin
               next_st.cnt = st.cnt - 8'h01;
            end else begin
               next_st.cnt = cyc8(PULSE_CYC);
               next_st.state = ST_STROBE;
               unique case (st.cmd)
                  CTC_CMD_WRITE: begin
                     next_st.pins.write_n = 1'b0;
                     next_st.pins.read_n = !st.arg[`CTC_PERR_BIT];
                  end
                  CTC_CMD_READ: next_st.pins.read_n = 1'b0;
                  CTC_CMD_WORD_RESET: next_st.pins.word_reset_n = 1'b0;
                  CTC_CMD_RESET: next_st.pins.reset_n = 1'b0;
                  CTC_CMD_UPDATE: next_st.pins.replace_update_strobe = 1'b0;
                  default: next_st.state = ST_SAMPLE;
               endcase
            end
         end
         ST_STROBE: begin
            if (st.cnt > 8'h01) begin
               next_st.cnt = st.cnt - 8'h01;
            end else begin
               next_st.cnt = cyc8(SETTLE_CYC);
               next_st.state = ST_HOLD;
               if (st.cmd == CTC_CMD_READ) begin
                  next_st.result[`CTC_TAG_W-1:0] = pin_sync.tag_in;
                  next_st.result[8] = !pin_sync.parity_fault_n;
               end
               next_st.pins.write_n = 1'b1;
               next_st.pins.read_n = 1'b1;
               next_st.pins.word_reset_n = 1'b1;
               next_st.pins.reset_n = 1'b1;
               next_st.pins.replace_update_strobe = 1'b1;
            end
         end
         ST_HOLD: begin
            // inputs held after strobe release
            if (st.cnt > 8'h01) begin
               next_st.cnt = st.cnt - 8'h01;
            end else begin
               next_st.state = ST_SAMPLE;
               next_st.cnt = cyc8(SETTLE_CYC);
            end
         end
         ST_SAMPLE: begin
            if (st.cnt > 8'h01) begin
               next_st.cnt = st.cnt - 8'h01;
            end else begin
               // compare result: hits, parity fault, replacement bank
               if (st.cmd != CTC_CMD_READ) begin
                  next_st.result[`CTC_TAG_W-1:0] = 4'h0;
                  next_st.result[8] = !pin_sync.parity_fault_n;
               end
               next_st.result[9] = pin_sync.hit_way_one;
               next_st.result[10] = pin_sync.hit_way_two;
               next_st.result[11] = pin_sync.bank;
               next_st.done = 1'b1;
               next_st.pins = idle_pins(st.arg);
               next_st.state = ST_IDLE;
            end
         end
         default: next_st.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.state <= ST_IDLE;
         st.cmd <= CTC_CMD_COMPARE;
         st.pins <= idle_pins(32'h00000000);
         st.pins.select_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign pins_out = st.pins;
endmodule

// ### ctc_defs.svh
// constants for the cache tag comparator controller
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH
`define CTC_ADDR_W 13
`define CTC_TAG_W 4
`define CTC_REG_CTRL 5'h00
`define CTC_REG_ARG 5'h04
`define CTC_REG_STATUS 5'h08
`define CTC_REG_RESULT 5'h0c
`define CTC_REG_TIMING 5'h10
`define CTC_CTRL_GO 0
`define CTC_STAT_BUSY 0
`define CTC_STAT_DONE 1
`define CTC_CMD_LSB 1
`define CTC_ADDR_LSB 0
`define CTC_TAG_LSB 16
`define CTC_BANK_CHOOSE_BIT 20
`define CTC_AUTO_BIT 21
`define CTC_PERR_BIT 22
`define CTC_PULSE_NS 60
`define CTC_CLK_NS 25
`define CTC_PULSE_CYC ((`CTC_PULSE_NS + `CTC_CLK_NS - 1) / `CTC_CLK_NS)
`define CTC_SETTLE_NS 30
`define CTC_SETTLE_CYC ((`CTC_SETTLE_NS + `CTC_CLK_NS - 1) / `CTC_CLK_NS)
`define CTC_RESP_OKAY 2'h0
`define CTC_RESP_SLVERR 2'h2
`endif

// ### ctc_pkg.sv
// types for the cache tag comparator controller
`include "ctc_defs.svh"
package ctc_pkg;
   typedef enum logic [2:0] {
      CTC_CMD_COMPARE = 3'h0,
      CTC_CMD_WRITE = 3'h1,
      CTC_CMD_READ = 3'h2,
      CTC_CMD_WORD_RESET = 3'h3,
      CTC_CMD_RESET = 3'h4,
      CTC_CMD_UPDATE = 3'h5
   } ctc_cmd_t;

   // device pins driven by the controller
   typedef struct packed {
      logic [`CTC_ADDR_W-1:0] addr;
      logic write_n;
      logic read_n;
      logic select_n;
      logic auto_mode;
      logic bank_choose;
      logic reset_n;
      logic word_reset_n;
      logic replace_update_strobe;
      logic [`CTC_TAG_W-1:0] tag_out;
      logic tag_oe;
   } ctc_pins_out_t;

   // device pins sensed by the controller, synchronised inside ctc_ctrl by ctc_sync
   typedef struct packed {
      logic hit_way_one;
      logic hit_way_two;
      logic parity_fault_n;
      logic bank;
      logic [`CTC_TAG_W-1:0] tag_in;
   } ctc_pins_in_t;
endpackage

// ### ctc_sync.sv
// two flip-flop synchroniser for the sensed device pins
`timescale 1ns/10ps
module ctc_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } ctc_sync_st_t;
   ctc_sync_st_t st;
   ctc_sync_st_t next_st;

   if (WIDTH < 1) begin : g_bad_width
      $error("ctc_sync width must be positive");
   end

   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule

// ### ctc_ctrl_chk.sv
// port assertions for the cache tag comparator controller
`timescale 1ns/10ps
module ctc_ctrl_chk #(
   parameter int PULSE_CYC = 3
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // device pins
   input wire ctc_pkg::ctc_pins_out_t pins_out
);
   import ctc_pkg::*;
   logic [7:0] low_cnt;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles the write strobe has been low
   always_ff @(posedge aclk)
      if (!aresetn || pins_out.write_n) low_cnt <= 8'h0;
      else low_cnt <= low_cnt + 8'h1;
   sequence s_strobe_held;
      !pins_out.write_n ##1 !pins_out.write_n;
   endsequence
   a_select_first: assert property ($fell(pins_out.write_n) |-> !$past(pins_out.select_n))
      else $error("write strobe fell without chip select");
   a_write_steady: assert property (s_strobe_held |-> $stable(pins_out.addr)
      && $stable(pins_out.tag_out) && $stable(pins_out.auto_mode) && $stable(pins_out.bank_choose))
      else $error("write inputs moved during strobe");
   a_write_clean: assert property (!pins_out.write_n |-> pins_out.reset_n
      && pins_out.word_reset_n && pins_out.tag_oe && !pins_out.select_n)
      else $error("bad pin state during write");
   a_pulse_width: assert property ($rose(pins_out.write_n) |-> low_cnt == PULSE_CYC)
      else $error("write strobe width wrong");
   a_word_manual: assert property (!pins_out.word_reset_n |-> !pins_out.auto_mode && pins_out.write_n)
      else $error("word reset outside manual mode");
   a_read_release: assert property (!pins_out.read_n && pins_out.write_n |-> !pins_out.tag_oe)
      else $error("tag bus driven during read");
   a_update_compare: assert property ($fell(pins_out.replace_update_strobe) |-> pins_out.write_n
      && pins_out.read_n && pins_out.word_reset_n && !pins_out.select_n)
      else $error("update strobe outside compare");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
endmodule
bind ctc_ctrl ctc_ctrl_chk #(.PULSE_CYC(PULSE_CYC)) ctc_ctrl_chk_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .pins_out(pins_out));

// ### ctc_dev_model.sv
// behavioural model of the two-way cache tag comparator device
`timescale 1ns/10ps
module ctc_dev_model (
   // pins from the controller
   input wire ctc_pkg::ctc_pins_out_t pins_out,
   // pins back to the controller
   output ctc_pkg::ctc_pins_in_t pins_in
);
   import ctc_pkg::*;
   logic [4:0] b1 [8192];
   logic [4:0] b2 [8192];
   logic lru [8192];
   logic held = 1'h0;
   logic [4:0] ent;
   wire [12:0] a = pins_out.addr;
   wire [3:0] t = pins_out.tag_out;
   wire [4:0] w1 = b1[a];
   wire [4:0] w2 = b2[a];
   wire [4:0] pk = pins_out.bank_choose ? w2 : w1;
   wire sel = !pins_out.select_n && pins_out.reset_n;
   wire cmp = sel && pins_out.write_n && pins_out.read_n
      && (pins_out.word_reset_n || pins_out.auto_mode);
   wire rdm = sel && pins_out.write_n && pins_out.word_reset_n && !pins_out.read_n;
   wire m1 = !cmp || w1 == {^t, t};
   wire m2 = !cmp || w2 == {^t, t};
   wire pf = cmp ? !(^w1 || ^w2) : !(rdm && ^pk);
   // released bus shows the inverse of the last driven tag
   wire [3:0] ti = rdm ? pk[3:0] : pins_out.tag_oe ? t : ~t;
   wire bk = pins_out.select_n ? 1'h1 : !pins_out.reset_n ? 1'h0 : !pins_out.write_n ? held
      : !pins_out.word_reset_n && !pins_out.auto_mode ? 1'h0 : lru[a];
   assign pins_in = {m1, m2, pf, bk, ti};
   always @(negedge pins_out.write_n) begin
      ent = pins_out.word_reset_n || pins_out.auto_mode ? {^t ^ !pins_out.read_n, t} : 5'h0;
      held = pins_out.auto_mode && lru[a];
      if (sel && (pins_out.auto_mode ? lru[a] : pins_out.bank_choose)) b2[a] = ent;
      else if (sel) b1[a] = ent;
      if (sel && pins_out.auto_mode) lru[a] = !lru[a];
   end
   always @(negedge pins_out.word_reset_n)
      if (sel && pins_out.write_n && !pins_out.auto_mode) begin
         if (pins_out.bank_choose) b2[a] = 5'h0;
         else b1[a] = 5'h0;
         lru[a] = pins_out.bank_choose;
      end
   always @(negedge pins_out.replace_update_strobe)
      if (cmp && (m1 || m2)) lru[a] = m1 && !m2;
   always @(negedge pins_out.reset_n)
      for (int i = 0; i < 8192; i++) begin
         b1[i] = 5'h0;
         b2[i] = 5'h0;
         lru[i] = 1'h0;
      end
endmodule

// ### ctc_ctrl_tb.sv
// testbench for the cache tag comparator controller
`timescale 1ns/10ps
module ctc_ctrl_tb;
   import ctc_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [4:0] awaddr = 5'h0, araddr = 5'h0;
   logic [31:0] wdata = 32'h0, rdata, r, res;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   ctc_pins_out_t po;
   ctc_pins_in_t pn;
   int errors = 0, check_count = 0;
   // argument, command, result mask, expected result
   logic [59:0] rows [17] = '{
      60'h00000000_4_700_600,
      60'h00050003_0_f00_000,
      60'h00250003_1_800_800,
      60'h00290003_1_800_000,
      60'h00050003_0_f00_200,
      60'h00090003_0_f00_400,
      60'h00100003_2_70f_009,
      60'h00100003_3_f00_c00,
      60'h00090003_0_f00_800,
      60'h002c0003_1_800_000,
      60'h000c0003_0_f00_400,
      60'h00050003_5_800_800,
      60'h00130005_1_f00_400,
      60'h00030005_0_f00_400,
      60'h00460007_1_f00_100,
      60'h00060007_0_700_100,
      60'h00000007_2_10f_106};
   ctc_ctrl ctc_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins_out(po), .pins_in(pn));
   ctc_dev_model ctc_dev_model_i (.pins_out(po), .pins_in(pn));
   initial forever #12.5 aclk = ~aclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      r = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   task automatic op(input logic [31:0] arg, input logic [3:0] cmd);
      int n = 0;
      wr(5'h04, arg);
      wr(5'h00, {27'h0, cmd, 1'h1});
      do begin
         rd(5'h08);
         n++;
      end while (r[1] !== 1'h1 && n < 100);
      // a command that never completes counts as a mismatch
      if (r[1] !== 1'h1) errors++;
      wr(5'h08, 32'h2);
      rd(5'h0c);
      res = r;
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #1500000;
      errors++;
      close_out;
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      rd(5'h08);
      chk(r, 32'h0);
      chk(po.select_n, 32'h1);
      rd(5'h10);
      chk(r, 32'h02030000);
      rd(5'h14);
      chk(r, 32'h0);
      chk(rs, 32'h2);
      wr(5'h14, 32'h0);
      chk(rs, 32'h2);
      foreach (rows[i]) begin
         op(rows[i][59:28], rows[i][27:24]);
         if (rows[i][23:12] !== 12'h0) chk(res[11:0] & rows[i][23:12], rows[i][11:0]);
      end
      // second reset in mid operation
      wr(5'h04, 32'h00050003);
      wr(5'h00, 32'h1);
      aresetn <= 1'h0;
      repeat (12) @(posedge aclk);
      chk(po.select_n, 32'h1);
      aresetn <= 1'h1;
      rd(5'h08);
      chk(r, 32'h0);
      chk(po.select_n, 32'h1);
      close_out;
   end
endmodule
